// ===== rtl/serial_display_defs.svh
`ifndef SERIAL_DISPLAY_DEFS_SVH
`define SERIAL_DISPLAY_DEFS_SVH
`define DATA_W        16
`define SET_W         8
`define PRE_LEN_W     4
`define FIFO_DEPTH    8
`define IDX_W         5
// fifo entry layout
`define F_RS          16
`define F_READ        17
`define F_DISP        18
`define F_LAST        19
`define F_W           20
// polarity bits: set means active high cs, inverted clock, inverted rs
`define POL_CS        0
`define POL_CLK       1
`define POL_RS        2
// reset values and start index of each data word
`define RST_CYC       9'h000
`define RST_IDX       5'h00
`define RST_WORD      16'h0000
`define LAST_DATA_IDX 5'h0F
`endif

// ===== rtl/serial_display_pkg.sv
package serial_display_pkg;
  typedef enum logic [1:0] {
    MODE_3W,
    MODE_4W,
    MODE_5W_CLK,
    MODE_5W_CS
  } link_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_HDR,
    ST_DATA,
    ST_WAIT,
    ST_GAP
  } seq_state_t;
endpackage : serial_display_pkg

// ===== rtl/async_display_serial_port.sv
// What this block does
// [RL1] read bit period: ceil(read period/base)
// [RL2] write bit period: ceil(write period/base)
// [RL3] read clock edges in half cycles
// [RL4] write clock edges in half cycles
// [RL5] settings held; sample point ceil whole cycles
// [RL6] four link variants: 3w, 4w, two 5w
// [RL7] 3-wire: one shared data line plus output enable
// [RL8] 4-wire: separate in/out lines, no sharing
// [RL9] optional preamble, configurable length and value
// [RL10] rw and rs header bits, configurable order
// [RL11] rw header bit can be disabled
// [RL12] header followed by word or burst
// [RL13] separate framing settings per display
// [RL14] 5-wire rs changes only at word boundaries
// [RL15] active-low cs, straight clock when configured
// [RL16] polarity register selects control polarities
// [RL17] msb first, one bit per clock, cs held
// [RL18] cs released after last word, wait request
`timescale 1ns/1ns
`include "serial_display_defs.svh"

module word_fifo #(
  parameter int WIDTH = `F_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : word_fifo

module async_display_serial_port (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         reset,
  // word stream in
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [`DATA_W-1:0]           in_data,
  input  wire logic                         in_rs,
  input  wire logic                         in_read,
  input  wire logic                         in_disp,
  input  wire logic                         in_last,
  // read data out
  output logic                              rd_valid,
  output logic [`DATA_W-1:0]                rd_data,
  output logic                              rd_disp,
  // timing settings, index 0 is display 1
  input  wire logic [`SET_W-1:0]            base_clock_period_setting,
  input  wire logic [1:0][`SET_W-1:0]       read_cycle_period_setting,
  input  wire logic [1:0][`SET_W-1:0]       write_cycle_period_setting,
  input  wire logic [1:0][`SET_W-1:0]       read_fall_time_setting,
  input  wire logic [1:0][`SET_W-1:0]       read_rise_time_setting,
  input  wire logic [1:0][`SET_W-1:0]       write_fall_time_setting,
  input  wire logic [1:0][`SET_W-1:0]       write_rise_time_setting,
  input  wire logic [1:0][`SET_W-1:0]       read_sample_point_setting,
  // framing settings per display, polarity shared by both
  input  wire logic [1:0][1:0]              link_mode,
  input  wire logic [1:0][`PRE_LEN_W-1:0]   preamble_length,
  input  wire logic [1:0][`DATA_W-1:0]      preamble_value,
  input  wire logic [1:0]                   rw_bit_enable,
  input  wire logic [1:0]                   rw_bit_first,
  input  wire logic [2:0]                   display_signal_polarity,
  // status
  output logic                              busy,
  // display pins
  output logic [1:0]                        display_chip_select,
  output logic                              serial_display_clock,
  output logic                              serial_data_out_internal,
  output logic                              serial_data_output_enable_n,
  input  wire logic                         serial_data_in_internal,
  output logic                              register_select_bit
);
  serial_display_pkg::seq_state_t state_q;
  serial_display_pkg::link_mode_t mode;
  logic [`F_W-1:0]     fifo_data;
  logic [`F_W-1:0]     ent_q;
  logic                fifo_valid;
  logic                take;
  logic                disp;
  logic                reading;
  logic [8:0]          cyc_q;
  logic [`IDX_W-1:0]   idx_q;
  logic [8:0]          per_c;
  logic [9:0]          rise_h;
  logic [9:0]          fall_h;
  logic [8:0]          samp_c;
  logic                bit_end;
  logic                in_frame;
  logic                bit_val;
  logic [`IDX_W-1:0]   hdr_top;
  logic [`IDX_W-1:0]   pre_top;
  logic                sdi_s1_q;
  logic                sdi_s2_q;
  logic                sdi_s3_q;
  logic                sdi_q;
  logic [`DATA_W-1:0]  rd_sh_q;
  logic                clk_a_q;
  logic                clk_b_q;
  logic                clk_n_q;
  logic [1:0]          cs_q;
  logic                sdo_q;
  logic                oe_n_q;
  logic                rs_q;

  function automatic logic [9:0] ceil_div(input logic [9:0] num, input logic [`SET_W-1:0] den);
    logic [10:0] d;
    logic [10:0] s;
    d = (den == '0) ? 11'h001 : {3'h0, den};
    s = {1'b0, num} + d - 11'h001;
    ceil_div = 10'(s / d);
  endfunction : ceil_div

  function automatic logic clk_level(input logic [9:0] h, input logic [9:0] r,
                                     input logic [9:0] f, input logic act);
    clk_level = !(act && (h >= r) && (h < f));
  endfunction : clk_level

  word_fifo #(.WIDTH(`F_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({in_last, in_disp, in_read, in_rs, in_data}),
    .out_valid (fifo_valid),
    .out_ready (take),
    .out_data  (fifo_data)
  );

  // [RL13] per-display selection
  assign disp    = ent_q[`F_DISP];
  assign mode    = serial_display_pkg::link_mode_t'(link_mode[disp]);
  assign reading = (state_q == serial_display_pkg::ST_DATA) && ent_q[`F_READ];
  assign hdr_top = rw_bit_enable[disp] ? 5'h01 : 5'h00;
  assign pre_top = `IDX_W'(preamble_length[fifo_data[`F_DISP]]) - 5'h01;

  // [RL1] [RL2] bit period by direction
  always_comb
  begin
    per_c = 9'(ceil_div(reading ? {2'b00, read_cycle_period_setting[disp]}
                                : {2'b00, write_cycle_period_setting[disp]},
                        base_clock_period_setting));
    if (per_c == 9'h000)
      per_c = 9'h001;
  end

  // [RL3] [RL4] edges in half periods
  assign rise_h = ceil_div(reading ? {1'b0, read_rise_time_setting[disp], 1'b0}
                                   : {1'b0, write_rise_time_setting[disp], 1'b0},
                           base_clock_period_setting);
  assign fall_h = ceil_div(reading ? {1'b0, read_fall_time_setting[disp], 1'b0}
                                   : {1'b0, write_fall_time_setting[disp], 1'b0},
                           base_clock_period_setting);

  // [RL5] sample point in whole cycles
  always_comb
  begin
    samp_c = 9'(ceil_div({2'b00, read_sample_point_setting[disp]},
                         base_clock_period_setting));
    if (samp_c >= per_c)
      samp_c = per_c - 9'h001;
  end

  assign in_frame = (state_q == serial_display_pkg::ST_PRE) ||
                    (state_q == serial_display_pkg::ST_HDR) ||
                    (state_q == serial_display_pkg::ST_DATA);
  assign bit_end  = in_frame && (cyc_q == per_c - 9'h001);
  assign take     = fifo_valid && ((state_q == serial_display_pkg::ST_IDLE) ||
                    (state_q == serial_display_pkg::ST_WAIT) ||
                    (state_q == serial_display_pkg::ST_DATA && bit_end &&
                     idx_q == '0 && !ent_q[`F_LAST]));
  assign busy     = (state_q != serial_display_pkg::ST_IDLE);

  // [RL10] [RL11] header bit order and suppression
  always_comb
  begin
    case (state_q)
      serial_display_pkg::ST_PRE:
        bit_val = preamble_value[disp][idx_q[3:0]];
      serial_display_pkg::ST_HDR:
        if (rw_bit_enable[disp] && ((idx_q == 5'h01) == rw_bit_first[disp]))
          bit_val = ent_q[`F_READ];
        else
          bit_val = ent_q[`F_RS];
      serial_display_pkg::ST_DATA:
        bit_val = ent_q[idx_q[3:0]];
      default:
        bit_val = 1'b0;
    endcase
  end

  // bit cell counter
  always_ff @(posedge mclk)
  begin
    if (reset || !in_frame || bit_end)
      cyc_q <= `RST_CYC;
    else
      cyc_q <= cyc_q + 9'h001;
  end

  // [RL9] [RL12] [RL17] [RL18] frame sequencer
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q <= serial_display_pkg::ST_IDLE;
      idx_q   <= `RST_IDX;
      ent_q   <= '0;
    end
    else
    begin
      if (take)
        ent_q <= fifo_data;
      case (state_q)
        serial_display_pkg::ST_IDLE:
          if (fifo_valid)
          begin
            if (preamble_length[fifo_data[`F_DISP]] != '0)
            begin
              state_q <= serial_display_pkg::ST_PRE;
              idx_q   <= pre_top;
            end
            else
            begin
              state_q <= serial_display_pkg::ST_HDR;
              idx_q   <= rw_bit_enable[fifo_data[`F_DISP]] ? 5'h01 : 5'h00;
            end
          end
        serial_display_pkg::ST_PRE:
          if (bit_end)
          begin
            state_q <= (idx_q == '0) ? serial_display_pkg::ST_HDR : state_q;
            idx_q   <= (idx_q == '0) ? hdr_top : idx_q - 5'h01;
          end
        serial_display_pkg::ST_HDR:
          if (bit_end)
          begin
            state_q <= (idx_q == '0) ? serial_display_pkg::ST_DATA : state_q;
            idx_q   <= (idx_q == '0) ? `LAST_DATA_IDX : idx_q - 5'h01;
          end
        serial_display_pkg::ST_DATA:
          if (bit_end)
          begin
            idx_q <= (idx_q == '0) ? `LAST_DATA_IDX : idx_q - 5'h01;
            if (idx_q == '0 && ent_q[`F_LAST])
              state_q <= serial_display_pkg::ST_GAP;
            else if (idx_q == '0 && !fifo_valid)
              state_q <= serial_display_pkg::ST_WAIT;
          end
        serial_display_pkg::ST_WAIT:
          if (fifo_valid)
            state_q <= serial_display_pkg::ST_DATA;
        serial_display_pkg::ST_GAP:
          state_q <= serial_display_pkg::ST_IDLE;
        default:
          state_q <= serial_display_pkg::ST_IDLE;
      endcase
    end
  end

  // data input pin: three stages, change counts when last two agree
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
      sdi_s3_q <= 1'b0;
      sdi_q    <= 1'b0;
    end
    else
    begin
      sdi_s1_q <= serial_data_in_internal;
      sdi_s2_q <= sdi_s1_q;
      sdi_s3_q <= sdi_s2_q;
      if (sdi_s2_q == sdi_s3_q)
        sdi_q <= sdi_s3_q;
    end
  end

  // [RL5] read capture at sample point, msb first
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rd_sh_q  <= `RST_WORD;
      rd_data  <= `RST_WORD;
      rd_valid <= 1'b0;
      rd_disp  <= 1'b0;
    end
    else
    begin
      rd_valid <= reading && bit_end && (idx_q == '0);
      if (reading && cyc_q == samp_c)
        rd_sh_q <= {rd_sh_q[`DATA_W-2:0], sdi_q};
      if (reading && bit_end && idx_q == '0)
      begin
        rd_data <= (samp_c == per_c - 9'h001) ? {rd_sh_q[`DATA_W-2:0], sdi_q} : rd_sh_q;
        rd_disp <= disp;
      end
    end
  end

  // [RL6] [RL7] [RL8] [RL14] [RL15] [RL16] pin drivers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cs_q    <= {2{!display_signal_polarity[`POL_CS]}};
      sdo_q   <= 1'b0;
      oe_n_q  <= 1'b1;
      rs_q    <= 1'b0;
      clk_a_q <= 1'b1;
      clk_b_q <= 1'b1;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
        cs_q[i] <= ((in_frame || state_q == serial_display_pkg::ST_WAIT) && disp == i[0])
                   ^ !display_signal_polarity[`POL_CS];
      sdo_q   <= in_frame && !reading && bit_val;
      oe_n_q  <= (mode == serial_display_pkg::MODE_3W) ? !(in_frame && !reading) : 1'b0;
      if ((mode == serial_display_pkg::MODE_5W_CLK || mode == serial_display_pkg::MODE_5W_CS)
          && state_q == serial_display_pkg::ST_DATA && cyc_q == 9'h000 && idx_q == `LAST_DATA_IDX)
        rs_q  <= ent_q[`F_RS] ^ display_signal_polarity[`POL_RS];
      clk_a_q <= clk_level({cyc_q, 1'b0}, rise_h, fall_h, in_frame)
                 ^ display_signal_polarity[`POL_CLK] ^ clk_n_q;
      clk_b_q <= clk_level({cyc_q, 1'b1}, rise_h, fall_h, in_frame)
                 ^ display_signal_polarity[`POL_CLK];
    end
  end

  // second half of each cycle carries the odd half-period level
  // pin is the xor of both flops: one flop moves per edge, so no glitch
  always_ff @(negedge mclk)
  begin
    if (reset)
      clk_n_q <= 1'b0;
    else
      clk_n_q <= clk_b_q ^ clk_a_q;
  end

  assign serial_display_clock        = clk_a_q ^ clk_n_q;
  assign display_chip_select         = cs_q;
  assign serial_data_out_internal    = sdo_q;
  assign serial_data_output_enable_n = oe_n_q;
  assign register_select_bit         = rs_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  frame_cs_held_a: assert property (in_frame |=> cs_q[$past(disp)] == display_signal_polarity[`POL_CS]) // [RL17]
    else $error("chip select not active inside frame");
  cs_release_a: assert property (state_q == serial_display_pkg::ST_GAP
      |=> cs_q == {2{!display_signal_polarity[`POL_CS]}}) // [RL18]
    else $error("chip select not released after last word");
  bit_period_a: assert property (in_frame |-> cyc_q < per_c) // [RL1]
    else $error("bit cell longer than period");
  read_oe_a: assert property (reading && mode == serial_display_pkg::MODE_3W |=> oe_n_q) // [RL7]
    else $error("3-wire line driven during read");
  write_oe_a: assert property (state_q == serial_display_pkg::ST_HDR |=> !oe_n_q) // [RL7]
    else $error("header not driven");
  four_wire_oe_a: assert property (mode == serial_display_pkg::MODE_4W |=> !oe_n_q) // [RL8]
    else $error("4-wire output released");
  rs_word_a: assert property (!(state_q == serial_display_pkg::ST_DATA && cyc_q == 9'h000
      && idx_q == `LAST_DATA_IDX) |=> $stable(rs_q)) // [RL14]
    else $error("rs changed inside word");
  no_rw_hdr_a: assert property (state_q == serial_display_pkg::ST_HDR && !rw_bit_enable[disp]
      |-> idx_q == '0) // [RL11]
    else $error("rw bit sent while disabled");
  pre_skip_a: assert property (state_q == serial_display_pkg::ST_IDLE && fifo_valid
      && preamble_length[fifo_data[`F_DISP]] == '0 |=> state_q == serial_display_pkg::ST_HDR) // [RL9]
    else $error("preamble sent with zero length");
  idle_wait_a: assert property (state_q == serial_display_pkg::ST_IDLE && !fifo_valid
      |=> state_q == serial_display_pkg::ST_IDLE) // [RL18]
    else $error("frame started without request");

  read_word_c: cover property (rd_valid);
  burst_wait_c: cover property (state_q == serial_display_pkg::ST_WAIT ##[1:20] state_q == serial_display_pkg::ST_DATA);
  preamble_c: cover property (state_q == serial_display_pkg::ST_PRE ##[1:200] state_q == serial_display_pkg::ST_GAP);
  fifo_full_c: cover property (!in_ready);
endmodule : async_display_serial_port

// ===== bench/display_model.sv
`timescale 1ns/1ns
module display_model (
  // link pins, seen as active low select and straight clock
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        sdo,
  input  wire logic        rs,
  input  wire logic        oe_n,
  // reply bits for reads, first bit on top
  input  wire logic [63:0] resp,
  output logic             sdi,
  // what the last frame carried
  output logic [8:0]       nbits,
  output logic [63:0]      bits,
  output logic [63:0]      rs_bits,
  output logic [63:0]      oe_bits,
  output logic [15:0]      low_ns,
  output logic [15:0]      per_ns
);
  time t_fall;
  initial
  begin
    t_fall = 0;
    nbits = 9'h000;
    bits = 64'h0;
    rs_bits = 64'h0;
    oe_bits = 64'h0;
    low_ns = 16'h0000;
    per_ns = 16'h0000;
    sdi = 1'b1;
  end
  always @(negedge cs_n)
  begin
    nbits <= 9'h000;
    sdi <= resp[63];
  end
  always @(negedge sclk)
  begin
    if (!cs_n)
    begin
      per_ns <= 16'($time - t_fall);
      t_fall = $time;
    end
  end
  // bit taken at rise, reply bit moves after it
  always @(posedge sclk)
  begin
    if (!cs_n)
    begin
      low_ns <= 16'($time - t_fall);
      bits <= {bits[62:0], sdo};
      rs_bits <= {rs_bits[62:0], rs};
      oe_bits <= {oe_bits[62:0], oe_n};
      nbits <= nbits + 9'h001;
      sdi <= resp[6'(9'h03E - nbits)];
    end
  end
  // released line shows the inverse of the last bit
  always @(posedge cs_n)
    sdi <= ~sdi;
endmodule : display_model

// ===== bench/test_async_display_serial_port.sv
`timescale 1ns/1ns
`include "serial_display_defs.svh"
module test_async_display_serial_port;
  logic                        mclk, reset, in_valid, in_ready, in_rs, in_read, in_disp, in_last;
  logic [15:0]                 in_data, rd_data, rd_seen;
  logic                        rd_valid, rd_disp, rd_disp_seen, busy, sclk_pin, sdo, oe_n, rs_pin;
  logic [1:0]                  cs;
  logic [`SET_W-1:0]           base;
  logic [1:0][`SET_W-1:0]      rp, wp, rfl, rrs, wfl, wrs, smp;
  logic [1:0][1:0]             mode;
  logic [1:0][`PRE_LEN_W-1:0]  pre_len;
  logic [1:0][`DATA_W-1:0]     pre_val;
  logic [1:0]                  rw_en, rw_first;
  logic [2:0]                  pol;
  logic                        sel, sdi_m, three_w, line_level, data_in;
  logic [8:0]                  nbits;
  logic [63:0]                 bits, rs_bits, oe_bits, resp;
  logic [15:0]                 low_ns, per_ns;
  int                          mismatches, n_tests, cyc, rd_cnt, full_cnt;

  always #20 mclk = ~mclk;

  // 3-wire: one line, driven by whoever has it
  assign three_w = (mode[sel] === 2'h0);
  assign line_level = (three_w && oe_n) ? sdi_m : sdo;
  assign data_in = three_w ? line_level : sdi_m;

  async_display_serial_port dut (
    .mclk(mclk), .reset(reset), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_rs(in_rs), .in_read(in_read), .in_disp(in_disp),
    .in_last(in_last), .rd_valid(rd_valid), .rd_data(rd_data), .rd_disp(rd_disp),
    .base_clock_period_setting(base), .read_cycle_period_setting(rp),
    .write_cycle_period_setting(wp), .read_fall_time_setting(rfl),
    .read_rise_time_setting(rrs), .write_fall_time_setting(wfl),
    .write_rise_time_setting(wrs), .read_sample_point_setting(smp),
    .link_mode(mode), .preamble_length(pre_len), .preamble_value(pre_val),
    .rw_bit_enable(rw_en), .rw_bit_first(rw_first), .display_signal_polarity(pol),
    .busy(busy), .display_chip_select(cs), .serial_display_clock(sclk_pin),
    .serial_data_out_internal(sdo), .serial_data_output_enable_n(oe_n),
    .serial_data_in_internal(data_in), .register_select_bit(rs_pin)
  );

  display_model far (
    .cs_n(cs[sel] ^ pol[0]), .sclk(sclk_pin ^ pol[1]), .sdo(line_level),
    .rs(rs_pin ^ pol[2]), .oe_n(oe_n), .resp(resp), .sdi(sdi_m), .nbits(nbits),
    .bits(bits), .rs_bits(rs_bits), .oe_bits(oe_bits), .low_ns(low_ns), .per_ns(per_ns)
  );

  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t ns: got %h want %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (rd_valid === 1'b1)
    begin
      rd_cnt <= rd_cnt + 1;
      rd_seen <= rd_data;
      rd_disp_seen <= rd_disp;
    end
    if (in_valid === 1'b1 && in_ready === 1'b0)
      full_cnt <= full_cnt + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic cfg(input logic d, input logic [1:0] m, input logic [3:0] pl,
                     input logic [15:0] pv, input logic re, input logic rf, input logic [2:0] p);
    @(posedge mclk);
    sel <= d;
    mode[d] <= m;
    pre_len[d] <= pl;
    pre_val[d] <= pv;
    rw_en[d] <= re;
    rw_first[d] <= rf;
    pol <= p;
  endtask : cfg

  // one frame of n words, then wait for the link to go quiet
  task automatic frame(input logic d, input logic rd, input logic [15:0] w0, input int n,
                       input logic rs0, input logic alt);
    int k;
    int i;
    for (i = 0; i < n; i++)
    begin
      in_valid <= 1'b1;
      in_data <= w0 + 16'(i);
      in_rs <= rs0 ^ (alt & i[0]);
      in_read <= rd;
      in_disp <= d;
      in_last <= (i == n - 1);
      k = 0;
      @(posedge mclk);
      while (in_ready !== 1'b1 && k < 4000)
      begin
        k++;
        @(posedge mclk);
      end
      if (k >= 4000)
        mismatches++;
    end
    in_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    k = 0;
    while (busy !== 1'b0 && k < 8000)
    begin
      k++;
      @(posedge mclk);
    end
    if (k >= 8000)
      mismatches++;
    repeat (4) @(posedge mclk);
  endtask : frame

  task automatic s_write();
    cfg(1'b0, serial_display_pkg::MODE_4W, 4'h0, 16'h0000, 1'b1, 1'b1, 3'h0);
    frame(1'b0, 1'b0, 16'hA5C3, 1, 1'b1, 1'b0);
    check(64'(nbits), 64'h0012);
    check(64'(bits[17:0]), 64'({2'b01, 16'hA5C3}));
    check(64'(oe_bits[17:0]), 64'h0);
    check(64'(per_ns), 64'h00A0);
    check(64'(low_ns), 64'h003C);
    check(64'(cs), 64'h0003);
    repeat (40) @(posedge mclk);
    check(64'(nbits), 64'h0012);
    check(64'(busy), 64'h0);
  endtask : s_write

  task automatic s_burst();
    cfg(1'b1, serial_display_pkg::MODE_5W_CLK, 4'h5, 16'h0016, 1'b0, 1'b0, 3'h0);
    frame(1'b1, 1'b0, 16'h1234, 2, 1'b0, 1'b1);
    check(64'(nbits), 64'h0026);
    check(64'(bits[37:0]), 64'({5'h16, 1'b0, 16'h1234, 16'h1235}));
    check(64'(rs_bits[31:0]), 64'({16'h0000, 16'hFFFF}));
    check(64'(per_ns), 64'h0050);
    check(64'(low_ns), 64'h0028);
  endtask : s_burst

  task automatic s_read();
    int c0;
    c0 = rd_cnt;
    resp <= {2'b00, 16'h3C5A, 46'h0};
    cfg(1'b0, serial_display_pkg::MODE_3W, 4'h0, 16'h0000, 1'b1, 1'b0, 3'h0);
    frame(1'b0, 1'b1, 16'h0000, 1, 1'b0, 1'b0);
    check(64'(bits[17:0]), 64'({2'b01, 16'h3C5A}));
    check(64'(oe_bits[17:0]), 64'({2'b00, 16'hFFFF}));
    check(64'(rd_cnt - c0), 64'h0001);
    check(64'(rd_seen), 64'h3C5A);
    check(64'(rd_disp_seen), 64'h0);
    check(64'(per_ns), 64'h0140);
    check(64'(low_ns), 64'h008C);
  endtask : s_read

  task automatic s_polarity();
    cfg(1'b1, serial_display_pkg::MODE_5W_CS, 4'h0, 16'h0000, 1'b1, 1'b1, 3'h7);
    repeat (2) @(posedge mclk);
    check(64'({cs, sclk_pin}), 64'h0);
    frame(1'b1, 1'b0, 16'h0F0F, 1, 1'b1, 1'b0);
    check(64'(bits[17:0]), 64'({2'b01, 16'h0F0F}));
    check(64'(rs_bits[15:0]), 64'hFFFF);
    cfg(1'b1, serial_display_pkg::MODE_5W_CS, 4'h0, 16'h0000, 1'b1, 1'b1, 3'h0);
    repeat (2) @(posedge mclk);
    check(64'({cs, sclk_pin}), 64'h0007);
  endtask : s_polarity

  task automatic s_fifo();
    cfg(1'b0, serial_display_pkg::MODE_4W, 4'h0, 16'h0000, 1'b1, 1'b1, 3'h0);
    frame(1'b0, 1'b0, 16'h1000, 10, 1'b0, 1'b0);
    check(64'(full_cnt > 0), 64'h1);
    check(64'(in_ready), 64'h1);
    check(64'(nbits), 64'h00A2);
    check(64'(bits[31:0]), 64'({16'h1008, 16'h1009}));
  endtask : s_fifo

  initial
  begin
    mclk = 1'b0;
    reset = 1'b1;
    {in_valid, in_rs, in_read, in_disp, in_last} = 5'h00;
    in_data = 16'h0000;
    base = 8'h02;
    rp = {8'h10, 8'h10};
    rfl = {8'h08, 8'h08};
    rrs = {8'h01, 8'h01};
    smp = {8'h0C, 8'h0C};
    wp = {8'h04, 8'h07};
    wfl = {8'h03, 8'h03};
    wrs = {8'h01, 8'h00};
    mode = 4'h5;
    pre_len = 8'h00;
    pre_val = 32'h0000_0000;
    rw_en = 2'h3;
    rw_first = 2'h3;
    pol = 3'h0;
    sel = 1'b0;
    resp = 64'h0;
    {mismatches, n_tests, cyc, rd_cnt, full_cnt} = '0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check(64'({busy, in_ready, cs, sclk_pin}), 64'h000F);
    s_write();
    s_burst();
    s_read();
    s_polarity();
    s_fifo();
    report_and_stop();
  end
endmodule : test_async_display_serial_port
